/* rtl/flash_update_uart_device.sv */
// slave end of the flash update link: port, pin select, write
// protection, serial channel registers and the polled frame engine.
// assumes the plain register port is driven on clk by one master.
// How it works
// - eight data bits per frame, asynchronous
// - no parity, one stop bit
// - data bits travel least significant first
// - holding registers pass data uninverted
// - sixteen base clock cycles per bit
// - receive noise filter bypassed
// - 25 MHz, divisor 18h gives 31250 bps
// - clock from internal generator, undivided
// - multiprocessor addressing off
// - transmit pin output high, receive input
// - both pins select function 1010b
// - pin select writes need lock cleared, enable
// - priority zero, requests masked, link polled
// - pending receive/transmit flags cleared at setup
// - top block programmed low, read high
// - master rewrites vectors after top erase
// - both ends share byte ordering
// - single-chip mode, program memory enabled
`timescale 1ns/1ns
module flash_update_uart_device
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [4:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic [7:0]      rdata,
	uart_link_if.device     link
);
	import uart_link_pkg::*;

	logic [7:0] port_out, port_dir, port_psel, wprotect, rx_pfs, tx_pfs;
	logic [7:0] ser_ctrl, frame_fmt, bit_order, sampling, brr, irq_prio;
	logic [7:0] rx_irq, tx_irq, irq_en, tx_hold, rx_hold, sys_ctrl;
	logic       tdre, rdrf, orer, fer;
	logic       pclk_en;
	logic [5:0] pre_cnt;
	logic [8:0] brg_cnt;
	logic       rx_meta, rx_sync;
	logic       eng_tx;
	logic       eng_busy;
	logic [7:0] eng_rx_byte;
	logic       eng_rx_done;
	logic       eng_rx_ferr;

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	wire wr_hit_tx   = wr && addr == ADDR_TX_HOLD;
	wire rd_hit_rx   = rd && addr == ADDR_RX_HOLD;
	wire wr_status   = wr && addr == ADDR_SER_STATUS;
	wire lock        = wprotect[LOCK_BIT];
	wire fsel_open   = !lock && wprotect[FSEL_WE_BIT];
	wire tx_periph   = port_psel[TX_PIN_BIT] && tx_pfs[3:0] == FUNC_SERIAL;
	wire rx_periph   = port_psel[RX_PIN_BIT] && rx_pfs[3:0] == FUNC_SERIAL;
	wire te          = ser_ctrl[TE_BIT];
	wire re          = ser_ctrl[RE_BIT];
	wire int_clk     = ser_ctrl[1:0] == CKSRC_INTERNAL;
	wire inv         = bit_order[DATA_INV_BIT];
	wire msb         = bit_order[BIT_DIR_BIT];
	wire [5:0] pre_lim = 6'((1 << (2 * frame_fmt[1:0])) - 1);
	wire [8:0] brg_lim = 9'({brr, 1'b1});
	wire pre_wrap    = pclk_en && pre_cnt >= pre_lim;
	wire base_tick   = int_clk && pre_wrap && brg_cnt >= brg_lim;
	wire tx_go       = te && !tdre && !eng_busy && tx_periph;
	// the filter is always bypassed, so its enable bit only stores
	wire rx_in       = rx_periph ? rx_sync : 1'b1;
	wire rx_take     = re && eng_rx_done;
	wire rx_room     = !rdrf || rd_hit_rx; // a read frees it now
	wire [7:0] status = {tdre, rdrf, orer, fer, 4'h0};
	wire [7:0] rx_view = shape_byte(eng_rx_byte, inv, msb);

	// ---------------------------------------------------------------
	// read mux
	// ---------------------------------------------------------------
	logic [7:0] next_rdata;
	always_comb begin
		unique case (addr)
		ADDR_PORT2_OUT:  next_rdata = port_out;
		ADDR_PORT2_DIR:  next_rdata = port_dir;
		ADDR_PORT2_PSEL: next_rdata = port_psel;
		ADDR_WPROTECT:   next_rdata = wprotect;
		ADDR_RX_PFS:     next_rdata = rx_pfs;
		ADDR_TX_PFS:     next_rdata = tx_pfs;
		ADDR_SER_CTRL:   next_rdata = ser_ctrl;
		ADDR_FRAME_FMT:  next_rdata = frame_fmt;
		ADDR_BIT_ORDER:  next_rdata = bit_order;
		ADDR_SAMPLING:   next_rdata = sampling;
		ADDR_BRR:        next_rdata = brr;
		ADDR_IRQ_PRIO:   next_rdata = irq_prio;
		ADDR_RX_IRQ:     next_rdata = rx_irq;
		ADDR_TX_IRQ:     next_rdata = tx_irq;
		ADDR_IRQ_EN:     next_rdata = irq_en;
		ADDR_TX_HOLD:    next_rdata = tx_hold;
		ADDR_RX_HOLD:    next_rdata = rx_hold;
		ADDR_SER_STATUS: next_rdata = status;
		ADDR_SYS_CTRL:   next_rdata = sys_ctrl;
		default:         next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= 8'h00;
		end else begin
			rdata <= rd ? next_rdata : 8'h00;
		end
	end

	// ---------------------------------------------------------------
	// plain configuration registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			port_out  <= RST_ZERO;
			port_dir  <= RST_ZERO;
			port_psel <= RST_ZERO;
			ser_ctrl  <= RST_ZERO;
			frame_fmt <= RST_ZERO;
			bit_order <= RST_BIT_ORDER;
			sampling  <= RST_ZERO;
			brr       <= RST_BRR;
			irq_prio  <= RST_ZERO;
			irq_en    <= RST_ZERO;
			tx_hold   <= RST_ZERO;
			sys_ctrl  <= RST_SYS_CTRL;
		end else if (wr) begin
			unique case (addr)
			ADDR_PORT2_OUT:  port_out  <= wdata;
			ADDR_PORT2_DIR:  port_dir  <= wdata;
			ADDR_PORT2_PSEL: port_psel <= wdata;
			ADDR_SER_CTRL:   ser_ctrl  <= wdata;
			ADDR_FRAME_FMT:  frame_fmt <= wdata;
			ADDR_BIT_ORDER:  bit_order <= wdata;
			ADDR_SAMPLING:   sampling  <= wdata;
			ADDR_BRR:        brr       <= wdata;
			ADDR_IRQ_PRIO:   irq_prio  <= wdata;
			ADDR_IRQ_EN:     irq_en    <= wdata;
			ADDR_TX_HOLD:    tx_hold   <= wdata;
			default: ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// write protection and pin function select
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			wprotect <= RST_WPROTECT;
			rx_pfs   <= RST_ZERO;
			tx_pfs   <= RST_ZERO;
		end else if (wr) begin
			if (addr == ADDR_WPROTECT) begin
				wprotect[LOCK_BIT] <= wdata[LOCK_BIT];
				// the enable only moves while the lock is open
				if (!lock) begin
					wprotect[FSEL_WE_BIT] <= wdata[FSEL_WE_BIT];
				end
			end
			if (addr == ADDR_RX_PFS && fsel_open) begin
				rx_pfs <= wdata;
			end
			if (addr == ADDR_TX_PFS && fsel_open) begin
				tx_pfs <= wdata;
			end
		end
	end

	// ---------------------------------------------------------------
	// bit-rate generator: pclk, prescaler, then 2*(divisor+1) per tick
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			pclk_en <= 1'b0;
			pre_cnt <= 6'h00;
			brg_cnt <= 9'h000;
		end else begin
			pclk_en <= !pclk_en;
			if (pclk_en) begin
				pre_cnt <= pre_wrap ? 6'h00 : pre_cnt + 6'h01;
			end
			if (pre_wrap) begin
				brg_cnt <= brg_cnt >= brg_lim ? 9'h000 : brg_cnt + 9'h001;
			end
		end
	end

	// ---------------------------------------------------------------
	// serial status and request flags; a set beats a clear, except tdre, where a hold write beats the set
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			tdre    <= 1'b1;
			rdrf    <= 1'b0;
			orer    <= 1'b0;
			fer     <= 1'b0;
			rx_hold <= RST_ZERO;
			rx_irq  <= RST_ZERO;
			tx_irq  <= RST_ZERO;
		end else begin
			if (wr_hit_tx) begin
				tdre <= 1'b0;
			end else if (tx_go) begin
				tdre <= 1'b1;
			end
			if (rx_take && rx_room) begin
				rx_hold <= rx_view;
				rdrf    <= 1'b1;
			end else if (rd_hit_rx) begin
				rdrf <= 1'b0;
			end
			if (rx_take && !rx_room) begin
				orer <= 1'b1;
			end else if (wr_status && !wdata[ST_ORER]) begin
				orer <= 1'b0;
			end
			if (rx_take && eng_rx_ferr) begin
				fer <= 1'b1;
			end else if (wr_status && !wdata[ST_FER]) begin
				fer <= 1'b0;
			end
			// requests are only latched and polled, never delivered
			if (rx_take && rx_room) begin
				rx_irq <= 8'h01;
			end else if (wr && addr == ADDR_RX_IRQ) begin
				rx_irq <= wdata;
			end
			if (tx_go) begin
				tx_irq <= 8'h01;
			end else if (wr && addr == ADDR_TX_IRQ) begin
				tx_irq <= wdata;
			end
		end
	end

	// ---------------------------------------------------------------
	// pins; receive pin passes two flip-flops first
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_meta       <= 1'b1;
			rx_sync       <= 1'b1;
			link.dev_tx    <= 1'b1;
			link.dev_tx_oe <= 1'b0;
		end else begin
			rx_meta       <= link.host_tx;
			rx_sync       <= rx_meta;
			link.dev_tx    <= tx_periph ? eng_tx : port_out[TX_PIN_BIT];
			link.dev_tx_oe <= tx_periph || port_dir[TX_PIN_BIT];
		end
	end

	uart_bit_engine u_engine (
		.clk          (clk),
		.rst          (rst),
		.tick         (base_tick),
		.tx_start     (tx_go),
		.tx_byte      (shape_byte(tx_hold, inv, msb)),
		.rx_line      (rx_in),
		.tx_line      (eng_tx),
		.tx_busy      (eng_busy),
		.rx_byte      (eng_rx_byte),
		.rx_done      (eng_rx_done),
		.rx_frame_err (eng_rx_ferr)
	);
endmodule

/* rtl/flash_update_uart_host.sv */
// master end of the flash update link: sends and receives raw bytes.
// assumes the user side runs on clk; frame layout matches the slave.
`timescale 1ns/1ns
module flash_update_uart_host
	import uart_link_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready,
	output logic [7:0]      rx_data,
	output logic            rx_valid,
	output logic            rx_frame_error,
	uart_link_if.host       link
);
	import uart_link_pkg::*;

	logic [6:0] tick_cnt;
	logic       line_meta;
	logic       line_sync;
	logic       eng_busy;
	logic [7:0] eng_byte;
	logic       eng_done;
	logic       eng_ferr;
	logic       eng_tx;

	wire tick = tick_cnt == 7'(HOST_TICK_CYC - 1);
	// bytes go out in the order the user offers them
	wire take = tx_valid && tx_ready;

	always_ff @(posedge clk) begin
		if (rst) begin
			tick_cnt       <= 7'h00;
			line_meta      <= 1'b1;
			line_sync      <= 1'b1;
			tx_ready       <= 1'b0;
			rx_data        <= 8'h00;
			rx_valid       <= 1'b0;
			rx_frame_error <= 1'b0;
			link.host_tx   <= 1'b1;
		end else begin
			tick_cnt       <= tick ? 7'h00 : tick_cnt + 7'h01;
			line_meta      <= link.dev_to_host;
			line_sync      <= line_meta;
			tx_ready       <= !eng_busy && !take;
			rx_valid       <= eng_done;
			link.host_tx   <= eng_tx;
			if (eng_done) begin
				rx_data        <= eng_byte;
				rx_frame_error <= eng_ferr;
			end
		end
	end

	uart_bit_engine u_engine (
		.clk          (clk),
		.rst          (rst),
		.tick         (tick),
		.tx_start     (take),
		.tx_byte      (tx_data),
		.rx_line      (line_sync),
		.tx_line      (eng_tx),
		.tx_busy      (eng_busy),
		.rx_byte      (eng_byte),
		.rx_done      (eng_done),
		.rx_frame_err (eng_ferr)
	);
endmodule

/* rtl/uart_bit_engine.sv */
// 8N1 frame engine: one transmitter and one receiver on a 16x tick.
// assumes rx_line is already synchronised to clk.
`timescale 1ns/1ns
module uart_bit_engine
	import uart_link_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       tick,
	input  wire logic       tx_start,
	input  wire logic [7:0] tx_byte,
	input  wire logic       rx_line,
	output logic            tx_line,
	output logic            tx_busy,
	output logic [7:0]      rx_byte,
	output logic            rx_done,
	output logic            rx_frame_err
);
	tx_state_t  tx_state;
	rx_state_t  rx_state;
	logic [9:0] tx_shift;
	logic [3:0] tx_sub;
	logic [3:0] tx_cnt;
	logic [3:0] rx_sub;
	logic [3:0] rx_cnt;
	logic       rx_prev;

	wire tx_bit_end = tick && tx_sub == LAST_SUB;
	wire rx_mid     = tick && rx_sub == MID_SAMPLE;
	wire rx_fall    = tick && rx_prev && !rx_line;

	assign tx_busy = tx_state == TX_SHIFT;

	// ---------------------------------------------------------------
	// transmitter
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_state <= TX_IDLE;
			tx_shift <= 10'h3FF;
			tx_sub   <= 4'h0;
			tx_cnt   <= 4'h0;
			tx_line  <= 1'b1;
		end else begin
			unique case (tx_state)
			TX_IDLE: begin
				tx_line <= 1'b1;
				if (tx_start) begin
					// stop, data lsb first, start
					tx_shift <= {1'b1, tx_byte, 1'b0};
					tx_sub   <= 4'h0;
					tx_cnt   <= 4'h0;
					tx_state <= TX_SHIFT;
				end
			end
			TX_SHIFT: begin
				// line moves on ticks only, so each bit is 16 whole ticks
				if (tick) begin
					tx_line <= tx_shift[0];
					tx_sub  <= tx_sub + 4'h1;
				end
				if (tx_bit_end) begin
					tx_shift <= {1'b1, tx_shift[9:1]};
					tx_cnt   <= tx_cnt + 4'h1;
					if (tx_cnt == 4'(FRAME_BITS - 1)) begin
						tx_state <= TX_IDLE;
					end
				end
			end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// receiver: falling edge, then sample at the middle of each bit
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_state     <= RX_IDLE;
			rx_sub       <= 4'h0;
			rx_cnt       <= 4'h0;
			rx_prev      <= 1'b1;
			rx_byte      <= 8'h00;
			rx_done      <= 1'b0;
			rx_frame_err <= 1'b0;
		end else begin
			rx_done <= 1'b0;
			if (tick) begin
				rx_prev <= rx_line;
				rx_sub  <= rx_sub + 4'h1;
			end
			unique case (rx_state)
			RX_IDLE: begin
				if (rx_fall) begin
					rx_sub   <= 4'h1;
					rx_state <= RX_START;
				end
			end
			RX_START: begin
				if (rx_mid) begin
					// a glitch shorter than half a bit is no start
					rx_cnt   <= 4'h0;
					rx_state <= rx_line ? RX_IDLE : RX_DATA;
				end
			end
			RX_DATA: begin
				if (rx_mid && rx_cnt < 4'(FRAME_DATA)) begin
					rx_byte <= {rx_line, rx_byte[7:1]};
					rx_cnt  <= rx_cnt + 4'h1;
				end else if (rx_mid) begin
					// single stop bit, no parity slot
					rx_frame_err <= !rx_line;
					rx_done      <= 1'b1;
					rx_state     <= RX_IDLE;
				end
			end
			default: rx_state <= RX_IDLE;
			endcase
		end
	end
endmodule

/* rtl/uart_link_if.sv */
// serial link between the flash update slave and its master.
// the line idles high through a pull-up when the slave pin is not driven.
`timescale 1ns/1ns
interface uart_link_if;
	logic dev_tx;
	logic dev_tx_oe;
	logic host_tx;
	logic dev_to_host;

	assign dev_to_host = dev_tx_oe ? dev_tx : 1'b1;

	modport device (
		input  host_tx,
		output dev_tx,
		output dev_tx_oe
	);
	modport host (
		input  dev_to_host,
		output host_tx
	);
endinterface

/* rtl/uart_link_pkg.sv */
// package for the flash update serial link: register map, field layout,
// reset values, rate constants and engine state types.
// assumes a single 50 MHz clock shared by both ends of the link.
package uart_link_pkg;

	// ---------------------------------------------------------------
	// clock and rate
	// ---------------------------------------------------------------
	localparam int unsigned CLK_HZ        = 50_000_000;
	localparam int unsigned PCLK_HZ       = 25_000_000;
	localparam int unsigned BIT_RATE      = 31_250;
	localparam int unsigned OVERSAMPLE    = 16;
	localparam int unsigned PCLK_DIV      = CLK_HZ / PCLK_HZ;
	localparam int unsigned HOST_TICK_CYC = CLK_HZ / (BIT_RATE * OVERSAMPLE);
	localparam int unsigned FRAME_DATA    = 8;
	localparam int unsigned FRAME_BITS    = FRAME_DATA + 2;
	localparam logic [3:0]  MID_SAMPLE    = 4'h7;
	localparam logic [3:0]  LAST_SUB      = 4'hF;

	// ---------------------------------------------------------------
	// register indices on the plain port
	// ---------------------------------------------------------------
	localparam logic [4:0] ADDR_PORT2_OUT    = 5'h00;
	localparam logic [4:0] ADDR_PORT2_DIR    = 5'h01;
	localparam logic [4:0] ADDR_PORT2_PSEL   = 5'h02;
	localparam logic [4:0] ADDR_WPROTECT     = 5'h03;
	localparam logic [4:0] ADDR_RX_PFS       = 5'h04;
	localparam logic [4:0] ADDR_TX_PFS       = 5'h05;
	localparam logic [4:0] ADDR_SER_CTRL     = 5'h06;
	localparam logic [4:0] ADDR_FRAME_FMT    = 5'h07;
	localparam logic [4:0] ADDR_BIT_ORDER    = 5'h08;
	localparam logic [4:0] ADDR_SAMPLING     = 5'h09;
	localparam logic [4:0] ADDR_BRR          = 5'h0A;
	localparam logic [4:0] ADDR_IRQ_PRIO     = 5'h0B;
	localparam logic [4:0] ADDR_RX_IRQ       = 5'h0C;
	localparam logic [4:0] ADDR_TX_IRQ       = 5'h0D;
	localparam logic [4:0] ADDR_IRQ_EN       = 5'h0E;
	localparam logic [4:0] ADDR_TX_HOLD      = 5'h0F;
	localparam logic [4:0] ADDR_RX_HOLD      = 5'h10;
	localparam logic [4:0] ADDR_SER_STATUS   = 5'h11;
	localparam logic [4:0] ADDR_SYS_CTRL     = 5'h12;

	// ---------------------------------------------------------------
	// field positions and codes
	// ---------------------------------------------------------------
	localparam int unsigned TX_PIN_BIT      = 0;
	localparam int unsigned RX_PIN_BIT      = 1;
	localparam int unsigned LOCK_BIT        = 7;
	localparam int unsigned FSEL_WE_BIT     = 6;
	localparam logic [3:0]  FUNC_SERIAL     = 4'hA;
	localparam int unsigned TE_BIT          = 5;
	localparam int unsigned RE_BIT          = 4;
	localparam logic [1:0]  CKSRC_INTERNAL  = 2'h0;
	localparam int unsigned DATA_INV_BIT    = 2;
	localparam int unsigned BIT_DIR_BIT     = 3;
	localparam int unsigned ST_TDRE         = 7;
	localparam int unsigned ST_RDRF         = 6;
	localparam int unsigned ST_ORER         = 5;
	localparam int unsigned ST_FER          = 4;
	localparam int unsigned ROM_EN_BIT      = 0;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] RST_ZERO      = 8'h00;
	localparam logic [7:0] RST_WPROTECT  = 8'h80;
	localparam logic [7:0] RST_BIT_ORDER = 8'hF2;
	localparam logic [7:0] RST_BRR       = 8'hFF;
	localparam logic [7:0] RST_SYS_CTRL  = 8'h01;

	// ---------------------------------------------------------------
	// top erase block map
	// ---------------------------------------------------------------
	localparam logic [31:0] TOP_BLOCK_PROG  = 32'h00FF_F800;
	localparam logic [31:0] TOP_BLOCK_READ  = 32'hFFFF_F800;
	localparam logic [31:0] FIXED_VECTORS   = 32'hFFFF_FF80;

	typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} rx_state_t;

	// optional inversion and msb-first reordering of a byte
	function automatic logic [7:0] shape_byte(input logic [7:0] b,
		input logic inv, input logic msb_first);
		logic [7:0] r;
		r = b;
		if (msb_first) begin
			for (int i = 0; i < 8; i++) begin
				r[i] = b[7 - i];
			end
		end
		shape_byte = inv ? ~r : r;
	endfunction

	// read-side address of the top block to its program/erase address
	function automatic logic [31:0] to_prog_addr(input logic [31:0] a);
		to_prog_addr = a - TOP_BLOCK_READ + TOP_BLOCK_PROG;
	endfunction

endpackage

/* testbench/flash_update_uart_link_assertions.sv */
// checker for the serial link: watches both wires of the interface.
// assumes the device runs at divisor 18h whenever it sends a frame.
`timescale 1ns/1ns
module flash_update_uart_link_assertions (
	input wire logic clk,
	input wire logic rst,
	input wire logic dev_tx,
	input wire logic dev_tx_oe,
	input wire logic host_tx,
	input wire logic dev_to_host
);
	// ---------------------------------------------------------------
	// frame position counters, zero while a line idles
	// ---------------------------------------------------------------
	int unsigned hpos;
	int unsigned dpos;

	// a frame is ten bits of 1600 clk, so position 15999 ends it
	always_ff @(posedge clk) begin
		if (rst) begin
			hpos <= 0;
			dpos <= 0;
		end else begin
			hpos <= (hpos == 15999 || (hpos == 0 && host_tx)) ?
				0 : hpos + 1;
			dpos <= (dpos == 15999 || (dpos == 0 && dev_to_host)) ?
				0 : dpos + 1;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_host_start; hpos == 800 |-> !host_tx; endproperty
	property p_host_stop; hpos == 15200 |-> host_tx; endproperty
	property p_host_edge;
		hpos != 0 && host_tx != $past(host_tx) |-> hpos % 1600 == 0;
	endproperty
	property p_dev_start; dpos == 800 |-> !dev_to_host; endproperty
	property p_dev_stop; dpos == 15200 |-> dev_to_host; endproperty
	property p_dev_edge;
		dpos != 0 && dev_to_host != $past(dev_to_host) |-> dpos % 1600 == 0;
	endproperty
	property p_oe_high; $rose(dev_tx_oe) |-> dev_tx; endproperty
	property p_reset_idle; $fell(rst) |-> host_tx && !dev_tx_oe; endproperty

	a_host_start: assert property (p_host_start)
		else $error("host start bit not low at mid bit");
	a_host_stop: assert property (p_host_stop)
		else $error("host stop bit not high");
	a_host_edge: assert property (p_host_edge)
		else $error("host line changed off a bit boundary");
	a_dev_start: assert property (p_dev_start)
		else $error("device start bit not low at mid bit");
	a_dev_stop: assert property (p_dev_stop)
		else $error("device stop bit not high");
	a_dev_edge: assert property (p_dev_edge)
		else $error("device line changed off a bit boundary");
	a_oe_high: assert property (p_oe_high)
		else $error("device pin enabled while driving low");
	a_reset_idle: assert property (p_reset_idle)
		else $error("link not idle after reset");

	c_host_frame: cover property (hpos == 15200);
	c_dev_frame: cover property (dpos == 15200);
	c_pin_on: cover property ($rose(dev_tx_oe));
endmodule

/* testbench/flash_update_uart_link_bench.sv */
// self-checking bench: device and host ends joined by the link interface.
// assumes the package register map and 1600 clk per bit after setup.
`timescale 1ns/1ns
module flash_update_uart_link_bench;
	import uart_link_pkg::*;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic [4:0] addr = 5'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic       tx_valid = 1'b0;
	logic [7:0] rdata;
	logic       tx_ready;
	logic [7:0] rx_data;
	logic       rx_valid;
	logic       rx_frame_error;
	int         fail_count = 0;
	int         n_compared = 0;
	int         cycles = 0;
	logic [4:0] rst_a [6] = '{ADDR_WPROTECT, ADDR_BIT_ORDER, ADDR_BRR,
		ADDR_SYS_CTRL, ADDR_SER_STATUS, 5'h1F};
	logic [7:0] rst_v [6] = '{RST_WPROTECT, RST_BIT_ORDER, RST_BRR,
		RST_SYS_CTRL, 8'h80, 8'h00};
	logic [4:0] set_a [16] = '{ADDR_RX_PFS, ADDR_TX_PFS, ADDR_WPROTECT,
		ADDR_WPROTECT, ADDR_PORT2_OUT, ADDR_PORT2_DIR, ADDR_PORT2_PSEL,
		ADDR_SER_CTRL, ADDR_FRAME_FMT, ADDR_BIT_ORDER, ADDR_SAMPLING,
		ADDR_BRR, ADDR_IRQ_PRIO, ADDR_IRQ_EN, ADDR_RX_IRQ, ADDR_TX_IRQ};
	logic [7:0] set_v [16] = '{8'h0A, 8'h0A, 8'h00, 8'h80, 8'h01, 8'h01,
		8'h03, 8'h30, 8'h00, 8'hF2, 8'h00, 8'h18, 8'h00, 8'h00, 8'h00,
		8'h00};
	logic [7:0] ovr [2] = '{8'h81, 8'h7E};

	uart_link_if lk ();

	flash_update_uart_device u_flash_update_uart_device (.clk(clk),
		.rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .link(lk));
	flash_update_uart_host u_flash_update_uart_host (.clk(clk), .rst(rst),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.rx_data(rx_data), .rx_valid(rx_valid),
		.rx_frame_error(rx_frame_error), .link(lk));
	flash_update_uart_link_assertions u_flash_update_uart_link_assertions (
		.clk(clk), .rst(rst), .dev_tx(lk.dev_tx), .dev_tx_oe(lk.dev_tx_oe),
		.host_tx(lk.host_tx), .dev_to_host(lk.dev_to_host));

	// ---------------------------------------------------------------
	// clock, timeout and shared tasks
	// ---------------------------------------------------------------
	always #10 clk = ~clk;

	// five frames need about 81000 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 100000) begin
			fail_count++;
			test_done();
		end
	end

	task automatic test_done;
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// a gap cycle keeps the strobe from being assigned twice at one edge
	task automatic wreg(input logic [4:0] a, input logic [7:0] d);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rchk(input logic [4:0] a, input logic [7:0] e);
		logic [7:0] d;
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
		check(d, e);
		@(posedge clk);
	endtask

	function automatic logic lvl(input logic from_host);
		return from_host ? lk.host_tx : lk.dev_to_host;
	endfunction

	// samples one frame at the middle of each bit
	task automatic watch(input logic from_host, input logic [7:0] e);
		logic [7:0] b;
		@(posedge clk iff lvl(from_host) === 1'b0);
		repeat (800) @(posedge clk);
		check({7'h00, lvl(from_host)}, 8'h00);
		for (int i = 0; i < 8; i++) begin
			repeat (1600) @(posedge clk);
			b[i] = lvl(from_host);
		end
		check(b, e);
		repeat (1600) @(posedge clk);
		check({7'h00, lvl(from_host)}, 8'h01);
	endtask

	task automatic send(input logic [7:0] d);
		tx_data  <= d;
		tx_valid <= 1'b1;
		@(posedge clk iff tx_ready === 1'b1);
		tx_valid <= 1'b0;
	endtask

	task automatic host_rx(input logic [7:0] e);
		@(posedge clk iff rx_valid === 1'b1);
		check(rx_data, e);
		check({7'h00, rx_frame_error}, 8'h00);
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		logic [31:0] pa;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		foreach (rst_a[i]) rchk(rst_a[i], rst_v[i]);
		pa = to_prog_addr(TOP_BLOCK_READ);
		check(pa[31:24], 8'h00);
		check(pa[15:8], 8'hF8);
		// the master rewrites the vectors at this program address after a top erase
		pa = to_prog_addr(FIXED_VECTORS);
		check(pa[31:24], 8'h00);
		check(pa[7:0], 8'h80);
		wreg(ADDR_RX_PFS, 8'h0A);
		rchk(ADDR_RX_PFS, 8'h00);
		wreg(ADDR_WPROTECT, 8'h40);
		rchk(ADDR_WPROTECT, 8'h00);
		wreg(ADDR_TX_PFS, 8'h0A);
		rchk(ADDR_TX_PFS, 8'h00);
		wreg(ADDR_WPROTECT, 8'h40);
		rchk(ADDR_WPROTECT, 8'h40);
		foreach (set_a[i]) wreg(set_a[i], set_v[i]);
		wreg(ADDR_RX_PFS, 8'h05);
		rchk(ADDR_RX_PFS, 8'h0A);
		rchk(ADDR_TX_PFS, 8'h0A);
		rchk(ADDR_BRR, 8'h18);
		rchk(ADDR_RX_IRQ, 8'h00);
		fork
			wreg(ADDR_TX_HOLD, 8'hA5);
			watch(1'b0, 8'hA5);
			host_rx(8'hA5);
		join
		rchk(ADDR_TX_IRQ, 8'h01);
		wreg(ADDR_TX_IRQ, 8'h00);
		rchk(ADDR_TX_IRQ, 8'h00);
		fork
			send(8'h3C);
			watch(1'b1, 8'h3C);
		join
		repeat (1600) @(posedge clk);
		rchk(ADDR_RX_IRQ, 8'h01);
		rchk(ADDR_SER_STATUS, 8'hC0);
		rchk(ADDR_RX_HOLD, 8'h3C);
		rchk(ADDR_SER_STATUS, 8'h80);
		for (int i = 0; i < 2; i++) begin
			fork
				send(ovr[i]);
				watch(1'b1, ovr[i]);
			join
		end
		repeat (1600) @(posedge clk);
		rchk(ADDR_SER_STATUS, 8'hE0);
		rchk(ADDR_RX_HOLD, 8'h81);
		wreg(ADDR_SER_STATUS, 8'h00);
		rchk(ADDR_SER_STATUS, 8'h80);
		// inverted msb-first shaping turns 01h into 7Fh on the line
		wreg(ADDR_BIT_ORDER, 8'hFE);
		fork
			wreg(ADDR_TX_HOLD, 8'h01);
			host_rx(8'h7F);
		join
		test_done();
	end
endmodule
